//--- tcp_pkg.sv
// constants shared by the two-channel timer: offsets, fields, reset values
// assumes a 32-bit AXI4-Lite register bus with byte addressing
package tcp_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned PRESC_W = 6;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_MODULO = 8'h08;
  localparam logic [7:0] OFS_CH0_CTL = 8'h0c;
  localparam logic [7:0] OFS_CH0_VAL = 8'h10;
  localparam logic [7:0] OFS_CH1_CTL = 8'h14;
  localparam logic [7:0] OFS_CH1_VAL = 8'h18;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h08;
  // main control fields
  localparam int unsigned CTRL_OVF_BIT = 7;
  localparam int unsigned CTRL_OIE_BIT = 6;
  localparam int unsigned CTRL_HALT_BIT = 5;
  localparam int unsigned CTRL_CRST_BIT = 4;
  localparam int unsigned CTRL_PS_LSB = 0;
  localparam int unsigned PS_W = 3;
  // channel control fields
  localparam int unsigned CH_FLAG_BIT = 7;
  localparam int unsigned CH_IE_BIT = 6;
  localparam int unsigned CH_MSH_BIT = 5;
  localparam int unsigned CH_MSL_BIT = 4;
  localparam int unsigned CH_ELH_BIT = 3;
  localparam int unsigned CH_ELL_BIT = 2;
  localparam int unsigned CH_TOV_BIT = 1;
  localparam int unsigned CH_MAX_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h20;
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  localparam logic [7:0] CHCTL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // edge/level, mode and bus response codes
  localparam logic [1:0] ELS_TOGGLE = 2'b01;
  localparam logic [1:0] ELS_CLEAR = 2'b10;
  localparam logic [1:0] ELS_SET = 2'b11;
  localparam logic [1:0] MS_CAPTURE = 2'b00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tcp_pkg

//--- tcp_prescaler.sv
// counter clock prescaler: one tick per 1,2,4,...,64 bus clocks
// assumes sel is stable software state; clear comes from the counter reset bit
`timescale 1ns/10ps
module tcp_prescaler #(
  parameter int unsigned W = tcp_pkg::PRESC_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clear,
  input wire logic [tcp_pkg::PS_W-1:0] sel,
  output logic tick
);
  import tcp_pkg::*;
  logic [W-1:0] div_reg;
  logic [W-1:0] div_next;
  logic [W-1:0] mask;

  always_comb begin
    // select 7 has no rate of its own: it repeats the slowest one
    mask = (sel >= PS_W'(W)) ? {W{1'b1}} : W'((1 << sel) - 1);
    tick = (div_reg & mask) == mask;
    div_next = clear ? '0 : div_reg + W'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end
endmodule : tcp_prescaler

//--- tcp_channel.sv
// one timer channel: pin synchroniser, capture edge detect, compare pin action
// assumes hits are one-cycle pulses from the counter logic on the same clock
`timescale 1ns/10ps
module tcp_channel (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_in,
  input wire logic capture_mode,
  input wire logic [1:0] edge_sel,
  input wire logic cmp_hit,
  input wire logic wrap_hit,
  input wire logic toggle_on_wrap,
  input wire logic full_duty,
  output logic pin_out,
  output logic capture_hit
);
  import tcp_pkg::*;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic pin_reg;
  logic pin_next;
  logic hold_high;

  always_comb begin
    // bit 0 selects rising, bit 1 falling, both bits either edge
    capture_hit = capture_mode &&
                  ((edge_sel[0] && sync2_reg && !prev_reg) ||
                   (edge_sel[1] && !sync2_reg && prev_reg));
    hold_high = full_duty && toggle_on_wrap;
    pin_next = pin_reg;
    if (!capture_mode) begin
      if (wrap_hit && toggle_on_wrap) begin
        pin_next = hold_high ? 1'b1 : !pin_reg;
      end
      // compare after wrap: a value of zero then gives zero duty
      if (cmp_hit && !hold_high) begin
        unique case (edge_sel)
          ELS_TOGGLE: pin_next = !pin_next;
          ELS_CLEAR: pin_next = 1'b0;
          ELS_SET: pin_next = 1'b1;
          default: pin_next = pin_next;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      pin_reg <= pin_next;
    end
  end

  assign pin_out = pin_reg;
endmodule : tcp_channel

//--- tcp_timer.sv
// two-channel capture/compare/PWM timer with AXI4-Lite register access
// assumes one clock (clk_sys), synchronous reset; channel pins are asynchronous
//
// How it works
// - 16-bit up-counter runs free or wraps at the modulo register value.
// - reading the counter never disturbs counting.
// - counter ticks at one of seven bus-clock rates from a 3-bit select.
// - each channel independently works as capture or compare.
// - selected pin edge copies the counter into the channel value register.
// - every qualifying edge overwrites the value, flag set or not.
// - capture or compare sets channel flag; irq only with enable set.
// - capture lands one clock cycle after the synchronised edge.
// - reset leaves channel value registers untouched.
// - compare match sets, clears or toggles the pin per edge/level bits.
// - compare fires only when counter actually reaches the value.
// - channel 0 upper mode bit links both channels onto channel 0 pin.
// - linked: channel 0 first, then last-written pair at each overflow.
// - linked: channel 1 control unused, channel 1 pin left as plain I/O.
// - toggle-on-overflow toggles the pin when counter wraps from modulo to zero.
// - modulo 0x00ff with select 000 gives a 256-cycle period.
// - value 0x0080 at 8-bit period gives 128 of 256 high.
// - overflow sets overflow flag; irq only with its enable.
// - mode 01 unbuffered, 10 buffered; edge/level 10 clear, 11 set.
// - full-duty bit with toggle gives 100%; without toggle it has no effect.
// - halt bit stops counting; reset bit clears counter and prescaler.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module tcp_timer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [tcp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcp_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chan0_pin_i,
  output logic chan0_pin_o,
  output logic chan0_pin_oe,
  input wire logic chan1_pin_i,
  output logic chan1_pin_o,
  output logic chan1_pin_oe,
  output logic overflow_irq,
  output logic chan0_irq,
  output logic chan1_irq
);
  import tcp_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // control and counter state
  logic ovf_flag_reg, ovf_flag_next;
  logic ovf_ie_reg, ovf_ie_next;
  logic halt_reg, halt_next;
  logic crst_reg, crst_next;
  logic [PS_W-1:0] ps_reg, ps_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] mod_reg, mod_next;
  logic [7:0] chctl_reg [NUM_CH];
  logic [7:0] chctl_next [NUM_CH];
  logic [CNT_W-1:0] chval_reg [NUM_CH];
  logic [CNT_W-1:0] chval_next [NUM_CH];
  logic act_sel_reg, act_sel_next;
  logic last_wr_reg, last_wr_next;
  logic [NUM_CH-1:0] oe_reg, oe_next;
  logic [2:0] irq_reg, irq_next;

  // bus state
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [AXI_AW-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // timing terms
  logic tick, run_tick, wrap;
  logic [CNT_W-1:0] cnt_inc;
  logic linked;
  logic [NUM_CH-1:0] cap_mode, cmp_mode, cmp_hit, cap_hit, pin_i, pin_o;
  logic [CNT_W-1:0] cmp_val [NUM_CH];
  logic [7:0] ctrl_view;
  logic do_wr;

  assign linked = chctl_reg[0][CH_MSH_BIT];
  assign ctrl_view = {ovf_flag_reg, ovf_ie_reg, halt_reg, 2'b00, ps_reg};
  assign pin_i = {chan1_pin_i, chan0_pin_i};

  tcp_prescaler #(.W(PRESC_W)) u_presc (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(crst_reg),
    .sel(ps_reg),
    .tick(tick)
  );

  always_comb begin
    run_tick = tick && !halt_reg && !crst_reg;
    wrap = run_tick && (cnt_reg == mod_reg);
    cnt_inc = wrap ? COUNT_RESET : cnt_reg + CNT_W'(1);
    for (int i = 0; i < NUM_CH; i++) begin
      // linked: channel 1 neither captures nor compares
      cap_mode[i] = (chctl_reg[i][CH_MSH_BIT:CH_MSL_BIT] == MS_CAPTURE) &&
                    !(i == 1 && linked);
      cmp_mode[i] = (chctl_reg[i][CH_MSH_BIT:CH_MSL_BIT] != MS_CAPTURE) &&
                    !(i == 1 && linked);
      cmp_val[i] = chval_reg[i];
    end
    if (linked) begin
      cmp_val[0] = act_sel_reg ? chval_reg[1] : chval_reg[0];
    end
    for (int i = 0; i < NUM_CH; i++) begin
      // matched against the value being entered, so a passed value fires only after the next wrap
      cmp_hit[i] = run_tick && cmp_mode[i] && (cnt_inc == cmp_val[i]);
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    tcp_channel u_ch (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_in(pin_i[g]),
      .capture_mode(cap_mode[g]),
      .edge_sel(chctl_reg[g][CH_ELH_BIT:CH_ELL_BIT]),
      .cmp_hit(cmp_hit[g]),
      .wrap_hit(wrap),
      .toggle_on_wrap(chctl_reg[g][CH_TOV_BIT]),
      .full_duty(chctl_reg[g][CH_MAX_BIT]),
      .pin_out(pin_o[g]),
      .capture_hit(cap_hit[g])
    );
  end

  // bus handshakes
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_wr) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (awaddr_reg[1:0] == 2'b00 && awaddr_reg <= OFS_CH1_VAL) ?
                   RESP_OKAY : RESP_SLVERR;
    end
    awready_next = !aw_held_next && !do_wr;
    wready_next = !w_held_next && !do_wr;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_next = {24'h0, ctrl_view};
        OFS_COUNT: rdata_next = {16'h0, cnt_reg};
        OFS_MODULO: rdata_next = {16'h0, mod_reg};
        OFS_CH0_CTL: rdata_next = {24'h0, chctl_reg[0]};
        OFS_CH0_VAL: rdata_next = {16'h0, chval_reg[0]};
        OFS_CH1_CTL: rdata_next = {24'h0, chctl_reg[1]};
        OFS_CH1_VAL: rdata_next = {16'h0, chval_reg[1]};
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  // register file and timer state
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    ovf_flag_next = ovf_flag_reg;
    ovf_ie_next = ovf_ie_reg;
    halt_next = halt_reg;
    crst_next = 1'b0;
    ps_next = ps_reg;
    mod_next = mod_reg;
    last_wr_next = last_wr_reg;
    act_sel_next = act_sel_reg;
    for (int i = 0; i < NUM_CH; i++) begin
      chctl_next[i] = chctl_reg[i];
      chval_next[i] = chval_reg[i];
    end
    if (do_wr) begin
      unique case (awaddr_reg)
        OFS_CTRL: begin
          m = merge({24'h0, ctrl_view}, wdata_reg, wstrb_reg);
          if (wstrb_reg[0] && !wdata_reg[CTRL_OVF_BIT]) begin
            ovf_flag_next = 1'b0;
          end
          ovf_ie_next = m[CTRL_OIE_BIT];
          halt_next = m[CTRL_HALT_BIT];
          crst_next = wstrb_reg[0] && wdata_reg[CTRL_CRST_BIT];
          ps_next = m[CTRL_PS_LSB +: PS_W];
        end
        OFS_MODULO: begin
          m = merge({16'h0, mod_reg}, wdata_reg, wstrb_reg);
          mod_next = m[CNT_W-1:0];
        end
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (awaddr_reg == OFS_CH0_CTL + OFS_CH_STRIDE * 8'(i)) begin
              m = merge({24'h0, chctl_reg[i]}, wdata_reg, wstrb_reg);
              chctl_next[i] = {chctl_reg[i][CH_FLAG_BIT], m[6:0]};
              if (wstrb_reg[0] && !wdata_reg[CH_FLAG_BIT]) begin
                chctl_next[i][CH_FLAG_BIT] = 1'b0;
              end
            end
            if (awaddr_reg == OFS_CH0_VAL + OFS_CH_STRIDE * 8'(i)) begin
              m = merge({16'h0, chval_reg[i]}, wdata_reg, wstrb_reg);
              chval_next[i] = m[CNT_W-1:0];
              last_wr_next = 1'(i);
            end
          end
        end
      endcase
    end
    // hardware events override a same-cycle software clear
    if (wrap) begin
      ovf_flag_next = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (cap_hit[i]) begin
        chval_next[i] = cnt_reg;
      end
      if (cap_hit[i] || cmp_hit[i]) begin
        chctl_next[i][CH_FLAG_BIT] = 1'b1;
      end
    end
    if (!linked) begin
      act_sel_next = 1'b0;
      last_wr_next = 1'b0;
    end else if (wrap) begin
      act_sel_next = last_wr_next;
    end
    if (crst_reg) begin
      cnt_next = COUNT_RESET;
    end else if (run_tick) begin
      cnt_next = cnt_inc;
    end else begin
      cnt_next = cnt_reg;
    end
    // drive follows the configuration being written, in step with the write response
    for (int i = 0; i < NUM_CH; i++) begin
      oe_next[i] = (chctl_next[i][CH_MSH_BIT:CH_MSL_BIT] != MS_CAPTURE) &&
                   !(i == 1 && chctl_next[0][CH_MSH_BIT]) &&
                   (chctl_next[i][CH_ELH_BIT:CH_ELL_BIT] != 2'b00);
    end
    irq_next[0] = ovf_flag_next && ovf_ie_next;
    irq_next[1] = chctl_next[0][CH_FLAG_BIT] && chctl_next[0][CH_IE_BIT];
    irq_next[2] = chctl_next[1][CH_FLAG_BIT] && chctl_next[1][CH_IE_BIT] && !linked;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ovf_flag_reg <= CTRL_RESET[CTRL_OVF_BIT];
      ovf_ie_reg <= CTRL_RESET[CTRL_OIE_BIT];
      halt_reg <= CTRL_RESET[CTRL_HALT_BIT];
      crst_reg <= 1'b0;
      ps_reg <= CTRL_RESET[CTRL_PS_LSB +: PS_W];
      cnt_reg <= COUNT_RESET;
      mod_reg <= MODULO_RESET;
      chctl_reg[0] <= CHCTL_RESET;
      chctl_reg[1] <= CHCTL_RESET;
      act_sel_reg <= 1'b0;
      last_wr_reg <= 1'b0;
      oe_reg <= '0;
      irq_reg <= '0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else begin
      ovf_flag_reg <= ovf_flag_next;
      ovf_ie_reg <= ovf_ie_next;
      halt_reg <= halt_next;
      crst_reg <= crst_next;
      ps_reg <= ps_next;
      cnt_reg <= cnt_next;
      mod_reg <= mod_next;
      chctl_reg[0] <= chctl_next[0];
      chctl_reg[1] <= chctl_next[1];
      act_sel_reg <= act_sel_next;
      last_wr_reg <= last_wr_next;
      oe_reg <= oe_next;
      irq_reg <= irq_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // channel values keep their contents through reset
  always_ff @(posedge clk_sys) begin
    chval_reg[0] <= chval_next[0];
    chval_reg[1] <= chval_next[1];
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign chan0_pin_o = pin_o[0];
  assign chan1_pin_o = pin_o[1];
  assign chan0_pin_oe = oe_reg[0];
  assign chan1_pin_oe = oe_reg[1];
  assign overflow_irq = irq_reg[0];
  assign chan0_irq = irq_reg[1];
  assign chan1_irq = irq_reg[2];
endmodule : tcp_timer

//--- tcp_timer_chk.sv
// port-level assertions for the two-channel timer
// assumes it is bound to tcp_timer; one clock, synchronous active-high reset
`timescale 1ns/10ps
module tcp_timer_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chan0_pin_oe,
  input wire logic chan1_pin_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("address accepted while write pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_ready_back: assert property ($past(reset) && !reset |=> ##[0:1] (s_axi_awready
    && s_axi_wready && s_axi_arready)) else $error("bus not ready after reset");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_oe0_cfg: assert property ($changed(chan0_pin_oe) |-> $rose(s_axi_bvalid))
    else $error("channel 0 drive changed without a write");
  a_oe1_cfg: assert property ($changed(chan1_pin_oe) |-> $rose(s_axi_bvalid))
    else $error("channel 1 drive changed without a write");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
  c_pin_drive: cover property ($rose(chan0_pin_oe));
endmodule : tcp_timer_chk

bind tcp_timer tcp_timer_chk chk_u (.clk_sys, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .chan0_pin_oe, .chan1_pin_oe);

//--- tcp_pin_env.sv
// far side of the two channel pins: outside sources against the timer's drive
// assumes no pull resistors; levels of the outside sources come from the bench
`timescale 1ns/10ps
module tcp_pin_env (
  input wire logic [1:0] ext_lvl,
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_i
);
  // a driven pin reads back its own level, an undriven one the outside source
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : ext_lvl[i];
    end
  end
endmodule : tcp_pin_env

//--- tb.sv
// self-checking bench for the two-channel timer over its register bus
// assumes tcp_pkg offsets and bit layout; pins see the bench's outside levels
`timescale 1ns/10ps
module tb;
  import tcp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lresp;
  logic [1:0] ext_lvl = 2'b00, pin_o, pin_oe, pin_i, irq;
  logic ovf_irq;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  tcp_timer dut_u (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan0_pin_i(pin_i[0]),
    .chan0_pin_o(pin_o[0]), .chan0_pin_oe(pin_oe[0]), .chan1_pin_i(pin_i[1]),
    .chan1_pin_o(pin_o[1]), .chan1_pin_oe(pin_oe[1]), .overflow_irq(ovf_irq),
    .chan0_irq(irq[0]), .chan1_irq(irq[1]));
  tcp_pin_env env_u (.ext_lvl(ext_lvl), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // a hang anywhere ends the run as a failure
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // entered and left just after a rising edge; ready is raised late to test holding
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    lresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    d = s_axi_rdata;
    lresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), v, e);
  endtask : rc
  task automatic hi_count(input int w, output int hi);
    hi = 0;
    repeat (w) begin
      @(posedge clk_sys);
      if (pin_o[0] === 1'b1) hi++;
    end
  endtask : hi_count
  task automatic rise(output int n);
    logic p;
    logic q;
    n = 0;
    p = pin_o[0];
    do begin
      @(posedge clk_sys);
      n++;
      q = p;
      p = pin_o[0];
    end while (!(q === 1'b0 && p === 1'b1) && n < 20000);
  endtask : rise
  // any window one period long holds exactly the pulse width
  task automatic pwm_chk(input int per, input int hi_exp);
    int n;
    int hi;
    rise(n);
    rise(n);
    chk("period", n, per);
    hi_count(per, hi);
    chk("pulse width", hi, hi_exp);
  endtask : pwm_chk
  task automatic do_reset;
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset
  logic [7:0] ctl_t [5] = '{8'h18, 8'h1c, 8'h14, 8'h1a, 8'h1b};
  int hi_t [5] = '{0, 64, 32, 32, 64};
  initial begin
    logic [31:0] c;
    int n;
    int h;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rc(OFS_CTRL, 32'(CTRL_RESET));
    rc(OFS_MODULO, 32'(MODULO_RESET));
    rc(OFS_CH0_CTL, 32'(CHCTL_RESET));
    rc(8'h1c, 32'h0);
    chk("unmapped resp", lresp, RESP_SLVERR);
    wr(OFS_COUNT, 32'h1234);
    rc(OFS_COUNT, 32'h0);
    wr(OFS_CH0_VAL, 32'h1234);
    do_reset();
    rc(OFS_CH0_VAL, 32'h1234);
    // capture against a halted counter so the expected value is exact
    wr(OFS_CTRL, 32'h00);
    repeat (20) @(posedge clk_sys);
    wr(OFS_CTRL, 32'h20);
    rd(OFS_COUNT, c);
    rc(OFS_COUNT, c);
    wr(OFS_CH1_CTL, 32'h44);
    ext_lvl[1] <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (irq[1] !== 1'b1 && n < 20);
    chk("capture delay", n, 4);
    rc(OFS_CH1_VAL, c);
    rc(OFS_CH1_CTL, 32'hc4);
    wr(OFS_CTRL, 32'h00);
    repeat (7) @(posedge clk_sys);
    wr(OFS_CTRL, 32'h20);
    rd(OFS_COUNT, c);
    ext_lvl[1] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    ext_lvl[1] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rc(OFS_CH1_VAL, c);
    wr(OFS_CH1_CTL, 32'h08);
    ext_lvl[1] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("irq masked", irq[1], 1'b0);
    rc(OFS_CH1_CTL, 32'h88);
    wr(OFS_CH1_CTL, 32'h0c);
    ext_lvl[1] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rc(OFS_CH1_CTL, 32'h8c);
    wr(OFS_CTRL, 32'h30);
    rc(OFS_COUNT, 32'h0);
    wr(OFS_MODULO, 32'h0f);
    wr(OFS_CH0_VAL, 32'h08);
    wr(OFS_CTRL, 32'h00);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CH0_CTL, 32'(ctl_t[i]));
      repeat (40) @(posedge clk_sys);
      hi_count(64, h);
      chk($sformatf("duty %h", ctl_t[i]), h, hi_t[i]);
    end
    rc(OFS_CTRL, 32'h80);
    wr(OFS_CTRL, 32'h40);
    repeat (20) @(posedge clk_sys);
    chk("overflow irq", ovf_irq, 1'b1);
    wr(OFS_CTRL, 32'h00);
    repeat (3) @(posedge clk_sys);
    chk("overflow irq off", ovf_irq, 1'b0);
    wr(OFS_CTRL, 32'h30);
    wr(OFS_MODULO, 32'hff);
    wr(OFS_CH0_VAL, 32'h80);
    wr(OFS_CH0_CTL, 32'h1a);
    wr(OFS_CTRL, 32'h00);
    pwm_chk(256, 128);
    wr(OFS_MODULO, 32'h0f);
    wr(OFS_CH0_VAL, 32'h08);
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CTRL, 32'(s));
      pwm_chk(16 << (s > 6 ? 6 : s), 8 << (s > 6 ? 6 : s));
    end
    wr(OFS_CTRL, 32'h40);
    do begin
      @(posedge clk_sys);
    end while (ovf_irq !== 1'b1);
    wr(OFS_CH0_VAL, 32'h0c);
    pwm_chk(16, 12);
    wr(OFS_CH0_CTL, 32'h5a);
    repeat (20) @(posedge clk_sys);
    chk("compare irq", irq[0], 1'b1);
    wr(OFS_CH0_CTL, 32'h1a);
    chk("compare irq off", irq[0], 1'b0);
    wr(OFS_CTRL, 32'h00);
    wr(OFS_CH1_VAL, 32'h02);
    wr(OFS_CH1_CTL, 32'h1c);
    repeat (20) @(posedge clk_sys);
    chk("chan1 pin", pin_o[1], 1'b1);
    chk("chan1 drive on", pin_oe[1], 1'b1);
    wr(OFS_CH0_VAL, 32'h04);
    wr(OFS_CH0_CTL, 32'h2a);
    pwm_chk(16, 4);
    chk("chan1 drive", pin_oe[1], 1'b0);
    wr(OFS_CH1_VAL, 32'h0c);
    pwm_chk(16, 12);
    wr(OFS_CH0_VAL, 32'h06);
    pwm_chk(16, 6);
    stop_test();
  end
endmodule : tb
